//--- include/imu_pkg.sv
// shared constants for the inertial output and sampling configuration block
// assumes a 100 MHz core clock; widths and offsets used by the config block and the testbench
package imu_pkg;

    localparam int      CLK_HZ            = 100_000_000;
    localparam longint  SAMPLE_RATE_MSPS  = 64'd819_200;  // 819.2 SPS in milli-samples/s
    localparam int      SAMPLE_DIV_CYCLES = int'(longint'(CLK_HZ) * 1000 / SAMPLE_RATE_MSPS);
    localparam int      BACKUP_MS         = 75;
    localparam int      BACKUP_CYCLES     = BACKUP_MS * (CLK_HZ / 1000);

    localparam int      NUM_CH     = 7;
    localparam int      DATA_W     = 14;
    localparam int      TEMP_W     = 12;
    localparam int      TEMP_CH    = 6;
    localparam int      FRAME_BITS = 16;
    localparam int      TAP_LOG_MAX = 7;

    localparam logic [6:0] ADDR_RATE_X  = 7'h04;
    localparam logic [6:0] ADDR_RATE_Y  = 7'h06;
    localparam logic [6:0] ADDR_RATE_Z  = 7'h08;
    localparam logic [6:0] ADDR_ACCEL_X = 7'h0A;
    localparam logic [6:0] ADDR_ACCEL_Y = 7'h0C;
    localparam logic [6:0] ADDR_ACCEL_Z = 7'h0E;
    localparam logic [6:0] ADDR_TEMP    = 7'h10;
    localparam logic [6:0] ADDR_SMPL    = 7'h36;
    localparam logic [6:0] ADDR_FILT    = 7'h38;
    localparam logic [6:0] ADDR_GCMD    = 7'h3E;
    localparam logic [6:0] OUT_ADDR [NUM_CH] = '{ADDR_RATE_X, ADDR_RATE_Y, ADDR_RATE_Z,
        ADDR_ACCEL_X, ADDR_ACCEL_Y, ADDR_ACCEL_Z, ADDR_TEMP};

    localparam logic [15:0] SMPL_RESET = 16'h0001;
    localparam logic [15:0] FILT_RESET = 16'h0402;
    localparam logic [15:0] SMPL_MASK  = 16'h1F01;
    localparam logic [15:0] FILT_MASK  = 16'h0707;

    localparam int FRESH_BIT   = 15;
    localparam int ERR_BIT     = 14;
    localparam int WR_BIT      = 15;
    localparam int CLK_SEL_BIT = 0;
    localparam int DEC_LSB     = 8;
    localparam int DEC_MSB     = 12;
    localparam int RANGE_LSB   = 8;
    localparam int RANGE_MSB   = 10;
    localparam int TAP_MSB     = 2;
    localparam int BACKUP_BIT  = 3;

    localparam logic [2:0] RANGE_300   = 3'h4;
    localparam logic [2:0] RANGE_150   = 3'h2;
    localparam logic [2:0] RANGE_75    = 3'h1;
    localparam logic [2:0] TAP_MIN_150 = 3'h2;
    localparam logic [2:0] TAP_MIN_75  = 3'h4;

    typedef enum logic [1:0] {
        ST_RESTORE = 2'b00,
        ST_RUN     = 2'b01,
        ST_BACKUP  = 2'b10
    } cfg_state_t;

    // lower ranges hold a floor on the tap exponent
    function automatic logic [2:0] floor_taps(input logic [2:0] rng, input logic [2:0] taps);
        if (rng == RANGE_75 && taps < TAP_MIN_75) begin
            return TAP_MIN_75;
        end
        if (rng == RANGE_150 && taps < TAP_MIN_150) begin
            return TAP_MIN_150;
        end
        return taps;
    endfunction

endpackage

//--- src/avg_stage.sv
// one moving-average stage of 2**taps_log taps over a ring of samples
// assumes in_valid pulses at the sample rate; clear empties the history
`timescale 1ns/1ns
`default_nettype none
module avg_stage #(
    parameter int W       = 14,
    parameter int LOG_MAX = 7
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                clear,
    input  wire logic                in_valid,
    input  wire logic signed [W-1:0] in_data,
    input  wire logic [2:0]          taps_log,
    output logic                     out_valid,
    output logic signed [W-1:0]      out_data
);
    localparam int DEPTH = 1 << LOG_MAX;
    localparam int SW    = W + LOG_MAX;

    logic signed [W-1:0]  hist [DEPTH];
    logic [LOG_MAX-1:0]   wp;
    logic [LOG_MAX-1:0]   rd_idx;
    logic [LOG_MAX:0]     span;
    logic signed [SW-1:0] sum;
    logic signed [SW-1:0] next_sum;

    ////////////////////////////////////////////////////////////////////////////////
    // running sum: add newest, drop the one that left the window
    always_comb begin
        span     = (LOG_MAX + 1)'(1) << taps_log;
        rd_idx   = wp - span[LOG_MAX-1:0];
        next_sum = sum + SW'(in_data) - SW'(hist[rd_idx]);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                hist[i] <= '0;
            end
        end else if (clear) begin
            for (int i = 0; i < DEPTH; i++) begin
                hist[i] <= '0;
            end
        end else if (in_valid) begin
            hist[wp] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp  <= '0;
            sum <= '0;
        end else if (clear) begin
            wp  <= '0;
            sum <= '0;
        end else if (in_valid) begin
            wp  <= wp + 1'b1;
            sum <= next_sum;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            out_valid <= in_valid && !clear;
            if (in_valid) begin
                out_data <= W'(next_sum >>> taps_log);
            end
        end
    end
endmodule
`default_nettype wire

//--- src/imu_output_and_sampling_config.sv
// inertial output registers, serial register access, sampling and filter config
// assumes sensor_data and sensor_error come from core_clk logic; sclk, cs_n, din
// and ext_clk are pins; the nonvolatile store sits outside on the flash_* ports
//
// Operation
// - fresh bit 15 sets on each output load, clears when that sample is read
// - bit 14 of every output word follows the error flag level
// - rate outputs are 14-bit two's complement in bits 13 to 0
// - acceleration outputs are 14-bit two's complement in bits 13 to 0
// - temperature is 12-bit signed in bits 11 to 0; bits 13, 12 zero
// - config access is per byte; low address is bits 7:0, next bits 15:8
// - write frame: bit 15 set, address in 14:8, data byte in 7:0
// - writes change working copy only; command bit 3 saves to flash
// - the flash save takes 75 ms
// - after reset every mirrored register reloads from its flash copy
// - internal clock with no decimation loads outputs at 819.2 SPS
// - decimation exponent D in sample-period bits 12:8 divides rate by 2**D
// - sample-period bit 0 picks internal clock; register resets to 0x0001
// - two cascaded moving averages of 2**B taps, B from filter bits 2:0
// - filter bits 10:8 pick range 300, 150 or 75; resets to 0x0402
// - tap exponent floors at 2 for 150 range and 4 for 75 range
// - read takes two 16-bit frames; reply comes in the second
// - serial clock idles high, sampled on rising edge, MSB first, 16 bits
`timescale 1ns/1ns
`default_nettype none
module imu_output_and_sampling_config
    import imu_pkg::*;
#(
    parameter int SAMPLE_DIV = SAMPLE_DIV_CYCLES,
    parameter int BACKUP_LEN = BACKUP_CYCLES
) (
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    input  wire logic                     sclk,
    input  wire logic                     cs_n,
    input  wire logic                     din,
    output logic                          dout,
    input  wire logic                     ext_clk,
    input  wire logic [NUM_CH*DATA_W-1:0] sensor_data,
    input  wire logic                     sensor_error,
    input  wire logic [31:0]              flash_rd_data,
    output logic                          flash_wr_en,
    output logic [31:0]                   flash_wr_data,
    output logic                          flash_busy,
    output logic                          sample_strobe
);
    localparam int ACC_W = DATA_W + 32;

    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [1:0]  din_s;
    logic [2:0]  ext_s;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        frame_start;
    logic [3:0]  bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [15:0] cmd_word;
    logic        cmd_valid;
    logic [6:0]  rd_addr;
    logic        rd_pending;
    logic [15:0] rd_word;
    logic [NUM_CH-1:0] rd_ch_hit;
    logic [NUM_CH-1:0] fresh;
    logic [DATA_W-1:0] held [NUM_CH];
    logic [15:0] sample_period_control;
    logic [15:0] filt_ctrl;
    cfg_state_t  state;
    logic        backup_req;
    logic [31:0] busy_cnt;
    logic [31:0] div_cnt;
    logic        tick;
    logic [2:0]  taps;
    logic [2:0]  taps_d;
    logic        taps_clear;
    logic [4:0]  dec_exp;
    logic [31:0] dec_cnt;
    logic        dec_valid;
    logic        dec_last;
    logic [NUM_CH-1:0] f1_valid;
    logic [NUM_CH-1:0] f2_valid;
    logic signed [DATA_W-1:0] f1_data [NUM_CH];
    logic signed [DATA_W-1:0] f2_data [NUM_CH];
    logic        wr_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; only the second stage onward is read
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_s <= 3'h7;
            cs_s   <= 3'h7;
            din_s  <= 2'h0;
            ext_s  <= 3'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk};
            cs_s   <= {cs_s[1:0], cs_n};
            din_s  <= {din_s[0], din};
            ext_s  <= {ext_s[1:0], ext_clk};
        end
    end

    assign sclk_rise   = sclk_s[1] && !sclk_s[2] && !cs_s[1];
    assign sclk_fall   = !sclk_s[1] && sclk_s[2] && !cs_s[1];
    assign frame_start = cs_s[2] && !cs_s[1];

    ////////////////////////////////////////////////////////////////////////////////
    // serial frame: 16 bits in, MSB first, reply shifted out on falling edges
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt   <= 4'h0;
            rx        <= 16'h0000;
            cmd_word  <= 16'h0000;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= 1'b0;
            if (frame_start) begin
                bit_cnt <= 4'h0;
            end else if (sclk_rise) begin
                rx      <= {rx[14:0], din_s[1]};
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == 4'(FRAME_BITS - 1)) begin
                    cmd_word  <= {rx[14:0], din_s[1]};
                    cmd_valid <= 1'b1;
                end
            end
        end
    end

    // reply for a read lands in the frame after the request
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_addr    <= 7'h00;
            rd_pending <= 1'b0;
            tx         <= 16'h0000;
            dout       <= 1'b0;
        end else begin
            if (cmd_valid && !cmd_word[WR_BIT]) begin
                rd_addr    <= cmd_word[14:8];
                rd_pending <= 1'b1;
            end else if (frame_start) begin
                rd_pending <= 1'b0;
            end
            if (frame_start) begin
                tx <= rd_pending ? rd_word : 16'h0000;
            end else if (sclk_fall) begin
                dout <= tx[15];
                tx   <= {tx[14:0], 1'b0};
            end
        end
    end

    // whole register read regardless of which byte address was asked
    always_comb begin
        rd_word   = 16'h0000;
        rd_ch_hit = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if ({rd_addr[6:1], 1'b0} == OUT_ADDR[c]) begin
                rd_word      = {fresh[c], sensor_error, held[c]};
                rd_ch_hit[c] = 1'b1;
            end
        end
        if ({rd_addr[6:1], 1'b0} == ADDR_SMPL) begin
            rd_word = sample_period_control;
        end
        if ({rd_addr[6:1], 1'b0} == ADDR_FILT) begin
            rd_word = filt_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration: restore at reset, byte writes, flash save
    assign wr_ok      = cmd_valid && cmd_word[WR_BIT] && state == ST_RUN;
    assign backup_req = wr_ok && cmd_word[14:8] == ADDR_GCMD && cmd_word[BACKUP_BIT];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sample_period_control  <= SMPL_RESET;
            filt_ctrl <= FILT_RESET;
        end else if (state == ST_RESTORE) begin
            sample_period_control  <= flash_rd_data[31:16] & SMPL_MASK;
            filt_ctrl <= {5'h00, flash_rd_data[10:8], 5'h00,
                          floor_taps(flash_rd_data[10:8], flash_rd_data[2:0])};
        end else if (wr_ok) begin
            case (cmd_word[14:8])
                ADDR_SMPL: begin
                    sample_period_control[7:0] <= cmd_word[7:0] & SMPL_MASK[7:0];
                end
                ADDR_SMPL + 7'h01: begin
                    sample_period_control[15:8] <= cmd_word[7:0] & SMPL_MASK[15:8];
                end
                ADDR_FILT: begin
                    filt_ctrl[2:0] <= floor_taps(filt_ctrl[RANGE_MSB:RANGE_LSB],
                                                 cmd_word[2:0]);
                end
                ADDR_FILT + 7'h01: begin
                    filt_ctrl[RANGE_MSB:RANGE_LSB] <= cmd_word[2:0];
                    // a range change may raise the taps, hence range first
                    filt_ctrl[2:0] <= floor_taps(cmd_word[2:0], filt_ctrl[2:0]);
                end
                default: begin
                end
            endcase
        end
    end

    // writes are refused to the config path while the save runs; reads are still answered
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state         <= ST_RESTORE;
            busy_cnt      <= 32'h0000_0000;
            flash_wr_en   <= 1'b0;
            flash_wr_data <= 32'h0000_0000;
            flash_busy    <= 1'b0;
        end else begin
            flash_wr_en <= 1'b0;
            case (state)
                ST_RESTORE: begin
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    if (backup_req) begin
                        flash_wr_en   <= 1'b1;
                        flash_wr_data <= {sample_period_control, filt_ctrl};
                        flash_busy    <= 1'b1;
                        busy_cnt      <= 32'(BACKUP_LEN - 1);
                        state         <= ST_BACKUP;
                    end
                end
                ST_BACKUP: begin
                    if (busy_cnt == 32'h0000_0000) begin
                        flash_busy <= 1'b0;
                        state      <= ST_RUN;
                    end else begin
                        busy_cnt <= busy_cnt - 32'h0000_0001;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample clock: internal divider or synchronised external rising edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 32'h0000_0000;
            tick    <= 1'b0;
        end else begin
            if (div_cnt == 32'(SAMPLE_DIV - 1)) begin
                div_cnt <= 32'h0000_0000;
            end else begin
                div_cnt <= div_cnt + 32'h0000_0001;
            end
            if (sample_period_control[CLK_SEL_BIT]) begin
                tick <= div_cnt == 32'(SAMPLE_DIV - 1);
            end else begin
                tick <= ext_s[1] && !ext_s[2];
            end
        end
    end

    // a tap change flushes both stages rather than mixing window lengths
    assign taps       = filt_ctrl[TAP_MSB:0];
    assign taps_clear = taps != taps_d;
    assign dec_exp    = sample_period_control[DEC_MSB:DEC_LSB];
    assign dec_valid  = f2_valid[0];
    // at or past the end: a smaller D must not strand the count above its limit
    assign dec_last   = dec_cnt >= ((32'h0000_0001 << dec_exp) - 32'h0000_0001);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            taps_d        <= 3'h0;
            dec_cnt       <= 32'h0000_0000;
            sample_strobe <= 1'b0;
        end else begin
            taps_d        <= taps;
            sample_strobe <= dec_valid && dec_last;
            if (dec_valid) begin
                dec_cnt <= dec_last ? 32'h0000_0000 : dec_cnt + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per channel: two averaging stages, decimating mean, held word, fresh flag
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic signed [ACC_W-1:0]  acc;
        logic signed [ACC_W-1:0]  next_acc;
        logic signed [DATA_W-1:0] mean;

        avg_stage #(.W(DATA_W), .LOG_MAX(TAP_LOG_MAX)) u_stage1 (
            .clk      (core_clk),
            .nrst     (nrst),
            .clear    (taps_clear),
            .in_valid (tick),
            .in_data  (sensor_data[c*DATA_W +: DATA_W]),
            .taps_log (taps),
            .out_valid(f1_valid[c]),
            .out_data (f1_data[c])
        );
        avg_stage #(.W(DATA_W), .LOG_MAX(TAP_LOG_MAX)) u_stage2 (
            .clk      (core_clk),
            .nrst     (nrst),
            .clear    (taps_clear),
            .in_valid (f1_valid[c]),
            .in_data  (f1_data[c]),
            .taps_log (taps),
            .out_valid(f2_valid[c]),
            .out_data (f2_data[c])
        );

        assign next_acc = acc + ACC_W'(f2_data[c]);
        assign mean     = DATA_W'(next_acc >>> dec_exp);

        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                acc     <= '0;
                held[c] <= '0;
            end else if (dec_valid) begin
                acc <= dec_last ? '0 : next_acc;
                if (dec_last) begin
                    if (c == TEMP_CH) begin
                        held[c] <= {2'b00, mean[TEMP_W-1:0]};
                    end else begin
                        held[c] <= mean;
                    end
                end
            end
        end

        // a new sample beats a read that retires the old one in the same cycle
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                fresh[c] <= 1'b0;
            end else if (dec_valid && dec_last) begin
                fresh[c] <= 1'b1;
            end else if (frame_start && rd_pending && rd_ch_hit[c]) begin
                fresh[c] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_FRESH_SET: assert property (dec_valid && dec_last |=> fresh[0])
        else $error("fresh flag not set on load");
    AST_FRESH_CLR: assert property (frame_start && rd_pending && rd_ch_hit[1]
        && !(dec_valid && dec_last) |=> !fresh[1])
        else $error("fresh flag not cleared by read");
    AST_ERR_BIT: assert property (frame_start && rd_pending && |rd_ch_hit
        |=> tx[ERR_BIT] == $past(sensor_error))
        else $error("error bit does not follow error level");
    AST_TEMP_PAD: assert property (frame_start && rd_pending && rd_ch_hit[TEMP_CH]
        |=> tx[13:12] == 2'b00)
        else $error("temperature unused bits not zero");
    AST_DEC_WRITE: assert property (wr_ok && cmd_word[14:8] == ADDR_SMPL + 7'h01
        |=> sample_period_control[DEC_MSB:DEC_LSB] == $past(cmd_word[4:0]))
        else $error("decimation byte write lost");
    AST_RANGE_FLOOR: assert property (state != ST_RESTORE
        && filt_ctrl[RANGE_MSB:RANGE_LSB] == RANGE_75 |-> taps >= TAP_MIN_75)
        else $error("tap floor for 75 range broken");
    AST_BACKUP_PULSE: assert property (backup_req && state == ST_RUN
        |=> flash_wr_en && flash_busy ##1 !flash_wr_en)
        else $error("flash save pulse wrong");
    AST_BACKUP_LEN: assert property ($rose(flash_busy)
        |-> busy_cnt == 32'(BACKUP_LEN - 1))
        else $error("flash save length wrong");
    AST_RESTORE: assert property (state == ST_RESTORE
        |=> sample_period_control == ($past(flash_rd_data[31:16]) & SMPL_MASK))
        else $error("restore from flash missing");
    AST_INT_TICK: assert property (sample_period_control[CLK_SEL_BIT]
        && div_cnt == 32'(SAMPLE_DIV - 1) && $stable(sample_period_control) |=> tick)
        else $error("internal sample tick missing");

    COV_LOAD: cover property (dec_valid && dec_last);
    COV_READ_REPLY: cover property (frame_start && rd_pending && rd_ch_hit[0]);
    COV_BACKUP_DONE: cover property ($fell(flash_busy));
    COV_EXT_TICK: cover property (!sample_period_control[CLK_SEL_BIT] && tick);
endmodule
`default_nettype wire

//--- verif/spi_host.sv
// serial host model: mode 3 master, 16-bit words, msb first
// assumes calls start on a core clock falling edge; phases are 80 ns
`timescale 1ns/1ns
`default_nettype none
module spi_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_n = 1'b0;
        #80;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            din  = tx[i];
            #80;
            sclk  = 1'b1;
            rx[i] = dout;
            #80;
        end
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        din = ~din;
        #80;
    endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the inertial output and sampling config block
// assumes the host model on the serial pins and short sample/backup counts
`timescale 1ns/1ns
`default_nettype none
module testbench
    import imu_pkg::*;
;
    localparam int DIV  = 40;
    localparam int BLEN = 20;
    logic                     core_clk = 1'b0;
    logic                     nrst = 1'b0;
    logic                     sclk, cs_n, din, dout;
    logic                     ext_clk = 1'b0;
    logic [NUM_CH*DATA_W-1:0] sensor_data = '0;
    logic                     sensor_error = 1'b0;
    logic [31:0]              flash_rd_data = 32'h0201_0100;
    logic                     flash_wr_en, flash_busy, sample_strobe;
    logic [31:0]              flash_wr_data, saved;
    int                       failures = 0;
    int                       comparisons = 0;
    int                       n, busy_n = 0, wr_n = 0;
    logic [15:0]              rx;
    logic [13:0]              smp [3];
    logic [13:0]              exp_f;
    always #5 core_clk = ~core_clk;
    imu_output_and_sampling_config #(.SAMPLE_DIV(DIV), .BACKUP_LEN(BLEN)) DUT (
        .core_clk(core_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .ext_clk(ext_clk), .sensor_data(sensor_data),
        .sensor_error(sensor_error), .flash_rd_data(flash_rd_data),
        .flash_wr_en(flash_wr_en), .flash_wr_data(flash_wr_data),
        .flash_busy(flash_busy), .sample_strobe(sample_strobe));
    spi_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    always @(posedge core_clk) begin
        busy_n <= busy_n + int'(flash_busy);
        if (flash_wr_en) begin
            saved <= flash_wr_data;
            wr_n  <= wr_n + 1;
        end
    end
    //////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({1'b1, a, d}, rx);
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] v);
        host.xfer({1'b0, a, 8'h00}, v);
        host.xfer(16'h0000, v);
    endtask
    // bounded wait; a missing strobe ends the run as a mismatch
    task automatic wait_strobe(output int cyc);
        cyc = 0;
        do begin
            @(negedge core_clk);
            cyc++;
        end while (sample_strobe !== 1'b1 && cyc < 5000);
        if (cyc >= 5000) begin
            failures++;
            close_out();
        end
    endtask
    function automatic logic [15:0] exp_word(input int c);
        logic [13:0] v;
        v = sensor_data[c*DATA_W +: DATA_W];
        if (c == TEMP_CH) v[13:12] = 2'b00;
        return {1'b1, sensor_error, v};
    endfunction
    // floor of the signed mean of two samples
    function automatic logic [13:0] avg2(input logic [13:0] x, input logic [13:0] y);
        int s;
        s = int'($signed(x)) + int'($signed(y));
        return DATA_W'(s >>> 1);
    endfunction
    // one external sample tick carrying v on the rate x lane
    task automatic ext_pulse(input logic [13:0] v, input logic load);
        sensor_data[DATA_W-1:0] = v;
        ext_clk = 1'b1;
        repeat (4) @(negedge core_clk);
        ext_clk = 1'b0;
        if (load) begin
            wait_strobe(n);
        end else begin
            repeat (4) @(negedge core_clk);
        end
    endtask
    //////////////////////////////////////////
    initial begin
        void'($urandom(49));
        repeat (16) @(negedge core_clk);
        nrst = 1'b1;
        repeat (8) @(negedge core_clk);
        rd(ADDR_SMPL, rx); chk(rx, 16'h0201);
        rd(ADDR_FILT, rx); chk(rx, 16'h0104);
        wr(ADDR_FILT + 7'h01, 8'h02);
        wr(ADDR_FILT, 8'h00);
        rd(ADDR_FILT, rx); chk(rx, 16'h0202);
        wr(ADDR_FILT + 7'h01, 8'h04);
        wr(ADDR_FILT, 8'h00);
        wr(ADDR_SMPL + 7'h01, 8'h00);
        rd(ADDR_FILT, rx); chk(rx, 16'h0400);
        rd(ADDR_SMPL, rx); chk(rx, 16'h0001);
        for (int c = 0; c < NUM_CH; c++) sensor_data[c*DATA_W +: DATA_W] = DATA_W'($urandom);
        sensor_error = 1'($urandom);
        wait_strobe(n);
        wait_strobe(n); chk(16'(n), 16'(DIV));
        wr(ADDR_SMPL, 8'h00);
        host.xfer({1'b0, OUT_ADDR[0], 8'h00}, rx);
        for (int c = 0; c < NUM_CH; c++) begin
            host.xfer({1'b0, OUT_ADDR[(c + 1) % NUM_CH], 8'h00}, rx);
            chk(rx, exp_word(c));
        end
        host.xfer(16'h0000, rx); chk(rx, exp_word(0) & 16'h7FFF);
        ext_clk = 1'b1;
        wait_strobe(n);
        ext_clk = 1'b0;
        rd(ADDR_RATE_Y, rx); chk(rx, exp_word(1));
        wr(ADDR_SMPL + 7'h01, 8'h02);
        wr(ADDR_SMPL, 8'h01);
        repeat (3) wait_strobe(n);
        chk(16'(n), 16'(4 * DIV));
        rd(ADDR_RATE_Z, rx); chk(rx, exp_word(2));
        wr(ADDR_GCMD, 8'h08);
        repeat (2 * BLEN) @(negedge core_clk);
        chk(16'(wr_n), 16'h0001);
        chk(saved[31:16], 16'h0201);
        chk(saved[15:0], 16'h0400);
        chk(16'(busy_n >= BLEN && busy_n <= BLEN + 1), 16'h0001);
        wr(ADDR_SMPL, 8'h00);
        wr(ADDR_SMPL + 7'h01, 8'h00);
        wr(ADDR_FILT, 8'h01);
        sensor_error = ~sensor_error;
        for (int i = 0; i < 3; i++) smp[i] = DATA_W'($urandom);
        for (int i = 0; i < 3; i++) ext_pulse(smp[i], 1'b1);
        exp_f = avg2(avg2(smp[0], smp[1]), avg2(smp[1], smp[2]));
        rd(ADDR_RATE_X, rx); chk(rx, {1'b1, sensor_error, exp_f});
        wr(ADDR_FILT, 8'h00);
        wr(ADDR_SMPL + 7'h01, 8'h01);
        ext_pulse(smp[2], 1'b0);
        ext_pulse(smp[0], 1'b1);
        exp_f = avg2(smp[2], smp[0]);
        rd(ADDR_RATE_X, rx); chk(rx, {1'b1, sensor_error, exp_f});
        close_out();
    end
endmodule
`default_nettype wire
